// file: hdl/bstap_top.sv
// Boundary-scan port with boundary cells for a row of user pins.
// Assumes test pins arrive on the test clock; core and pins on sys_clk_i.
`timescale 1ns/10ps
module bstap_top import bstap_pkg::*; #(
  parameter int NPIN = 4
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic in_system_programming_i,
  input wire logic programmed_i,
  input wire logic always_enable_inbuf_i,
  input wire logic [NPIN-1:0] pin_output_only_i,
  input wire logic [NPIN-1:0] core_out_i,
  input wire logic [NPIN-1:0] core_oe_i,
  input wire logic [NPIN-1:0] pin_in_i,
  output logic [NPIN-1:0] pin_out_o,
  output logic [NPIN-1:0] pin_oe_o,
  output logic [NPIN-1:0] core_in_o,
  output logic extest_active_o
);
  localparam int BSR_W = 3 * NPIN;

  // Test clock domain: no reset pin, tap resets via mode-select ones
  bstap_state_e state = ST_RESET;
  bstap_state_e next_state;
  logic [IR_W-1:0] ir_sh, next_ir_sh;
  logic [IR_W-1:0] ir = INS_BYPASS;
  logic [IR_W-1:0] next_ir;
  logic byp, next_byp;
  logic [BSR_W-1:0] bsr_cap, next_bsr_cap;
  logic [BSR_W-1:0] bsr_upd = '0;
  logic [BSR_W-1:0] next_bsr_upd;
  logic tdo_n, next_tdo_n;
  logic tdo_en, next_tdo_en;
  logic [1:0] isp_sync_t;
  logic upd_tgl = 1'b0;
  logic next_upd_tgl;
  logic [NPIN-1:0] pin_s1_t, pin_s2_t;
  logic isp_t;

  // Programming flag into test clock domain
  always_ff @(posedge tck_i) begin
    isp_sync_t[0] <= in_system_programming_i;
    isp_sync_t[1] <= isp_sync_t[0];
  end
  assign isp_t = isp_sync_t[1];

  logic [NPIN-1:0] pin_view_sys;
  always_ff @(posedge tck_i) begin
    pin_s1_t <= pin_view_sys;
    pin_s2_t <= pin_s1_t;
  end

  logic ins_extest, ins_sample, ins_bypass_like;
  always_comb begin
    ins_extest = (ir == INS_EXTEST) && !isp_t;
    ins_sample = (ir == INS_SAMPLE) && !isp_t;
    ins_bypass_like = !(ins_extest || ins_sample);
  end

  logic [BSR_W-1:0] cap_vec;
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      cap_vec[3*i] = pin_s2_t[i];
      cap_vec[3*i+1] = bsr_upd[3*i+1];
      cap_vec[3*i+2] = bsr_upd[3*i+2];
    end
  end

  always_comb begin
    next_state = bstap_next(state, tms_i);
    next_ir_sh = ir_sh;
    next_ir = ir;
    next_byp = byp;
    next_bsr_cap = bsr_cap;
    next_bsr_upd = bsr_upd;
    next_upd_tgl = upd_tgl;
    unique case (state)
      ST_RESET: next_ir = INS_BYPASS;
      ST_CAP_IR: next_ir_sh = IR_CAPTURE;
      ST_SH_IR: next_ir_sh = {tdi_i, ir_sh[IR_W-1:1]};
      ST_UPD_IR: next_ir = ir_sh;
      ST_CAP_DR: begin
        next_byp = 1'b0;
        if (!ins_bypass_like) next_bsr_cap = cap_vec;
      end
      ST_SH_DR: begin
        if (ins_bypass_like) next_byp = tdi_i;
        else next_bsr_cap = {tdi_i, bsr_cap[BSR_W-1:1]};
      end
      ST_UPD_DR: begin
        // Toggle tells the system side a new word stands
        if (!ins_bypass_like) begin
          next_bsr_upd = bsr_cap;
          next_upd_tgl = !upd_tgl;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge tck_i) begin
    state <= next_state;
    ir_sh <= next_ir_sh;
    ir <= next_ir;
    byp <= next_byp;
    bsr_cap <= next_bsr_cap;
    bsr_upd <= next_bsr_upd;
    upd_tgl <= next_upd_tgl;
  end

  // Port standard asks for output changes on the falling edge; tdo_n changes there, but tdo_o changes on sys_clk rising edges
  always_comb begin
    next_tdo_en = (state == ST_SH_IR) || (state == ST_SH_DR);
    if (state == ST_SH_IR) next_tdo_n = ir_sh[0];
    else if (ins_bypass_like) next_tdo_n = byp;
    else next_tdo_n = bsr_cap[0];
  end
  always_ff @(negedge tck_i) begin
    tdo_n <= next_tdo_n;
    tdo_en <= next_tdo_en;
  end

  // Crossing to the system clock domain
  logic ext_s1, ext_s2;
  logic tgl_s1, tgl_s2, tgl_s3;
  logic [BSR_W-1:0] upd_hold, next_upd_hold;
  logic tdo_s1, tdo_s2, tdoen_s1, tdoen_s2;
  logic ext_t;
  assign ext_t = ins_extest;
  always_ff @(posedge sys_clk_i) begin
    ext_s1 <= ext_t;
    ext_s2 <= ext_s1;
    tgl_s1 <= upd_tgl;
    tgl_s2 <= tgl_s1;
    tgl_s3 <= tgl_s2;
    tdo_s1 <= tdo_n;
    tdo_s2 <= tdo_s1;
    tdoen_s1 <= tdo_en;
    tdoen_s2 <= tdoen_s1;
  end

  // Update word is steady once its toggle has crossed
  always_comb begin
    next_upd_hold = upd_hold;
    if (tgl_s2 != tgl_s3) next_upd_hold = bsr_upd;
  end
  always_ff @(posedge sys_clk_i) begin
    upd_hold <= next_upd_hold;
  end

  logic [NPIN-1:0] pin_s1, pin_s2, inbuf_on;
  always_ff @(posedge sys_clk_i) begin
    pin_s1 <= pin_in_i;
    pin_s2 <= pin_s1;
  end
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      inbuf_on[i] = !programmed_i || always_enable_inbuf_i ||
                    !pin_output_only_i[i];
    end
  end
  // Registered so the test clock side samples a glitch-free view
  logic [NPIN-1:0] next_pin_view;
  assign next_pin_view = pin_s2 & inbuf_on;
  always_ff @(posedge sys_clk_i) begin
    pin_view_sys <= next_pin_view;
  end

  logic [NPIN-1:0] next_pin_out, next_pin_oe, next_core_in;
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (ext_s2) begin
        // Enable cell low means drive
        next_pin_oe[i] = !upd_hold[3*i+2];
        next_pin_out[i] = upd_hold[3*i+1];
      end else begin
        next_pin_oe[i] = core_oe_i[i];
        next_pin_out[i] = core_out_i[i];
      end
    end
    next_core_in = pin_view_sys;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pin_out_o <= '0;
      pin_oe_o <= '0;
      core_in_o <= '0;
      extest_active_o <= 1'b0;
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else begin
      pin_out_o <= next_pin_out;
      pin_oe_o <= next_pin_oe;
      core_in_o <= next_core_in;
      extest_active_o <= ext_s2;
      tdo_o <= tdo_s2;
      tdo_oe_o <= tdoen_s2;
    end
  end

  sequence s_enter_shift_ir;
    !tms_i ##1 tms_i ##1 tms_i ##1 !tms_i ##1 !tms_i;
  endsequence
  chk_tms_five_ones: assert property (@(posedge tck_i)
    tms_i [*5] |=> state == ST_RESET)
    else $error("five high mode-selects did not reset");
  chk_capture_ir_pattern: assert property (@(posedge tck_i)
    state == ST_CAP_IR |=> ir_sh == IR_CAPTURE)
    else $error("instruction capture pattern wrong");
  chk_reset_to_shift_ir: assert property (@(posedge tck_i)
    (state == ST_RESET) ##0 s_enter_shift_ir |=> state == ST_SH_IR)
    else $error("01100 did not reach shift-IR");
  chk_update_copies: assert property (@(posedge tck_i)
    state == ST_UPD_DR && !ins_bypass_like |=> bsr_upd == $past(bsr_cap))
    else $error("update cells not loaded");
  chk_isp_blocks_test: assert property (@(posedge tck_i)
    isp_t |-> ins_bypass_like)
    else $error("pin test active during programming");
  chk_bypass_path: assert property (@(posedge tck_i)
    state == ST_SH_DR && ir == INS_BYPASS |=> byp == $past(tdi_i))
    else $error("bypass bit not loaded");
  chk_extest_drive: assert property (@(posedge sys_clk_i)
    disable iff (srst_i)
    ext_s2 && !upd_hold[2] |=>
      pin_oe_o[0] && pin_out_o[0] == $past(upd_hold[1]))
    else $error("pin not driven from update cell");
  chk_inbuf_off: assert property (@(posedge sys_clk_i)
    disable iff (srst_i)
    programmed_i && !always_enable_inbuf_i && pin_output_only_i[0]
      |-> ##2 !core_in_o[0])
    else $error("input buffer of output pin not off");

  sequence s_dr_shift_step;
    state == ST_SH_DR && !ins_bypass_like;
  endsequence
  sequence s_ir_shift_step;
    state == ST_SH_IR;
  endsequence

  chk_ir_shift_in: assert property (@(posedge tck_i)
    s_ir_shift_step |=>
      ir_sh == {$past(tdi_i), $past(ir_sh[IR_W-1:1])})
    else $error("instruction shift wrong");

  chk_ir_first_bit: assert property (@(negedge tck_i)
    s_ir_shift_step |=>
      tdo_n == $past(ir_sh[0]))
    else $error("instruction bit not on data output");

  chk_ir_update: assert property (@(posedge tck_i)
    state == ST_UPD_IR |=>
      ir == $past(ir_sh))
    else $error("instruction not updated");

  chk_reset_bypass: assert property (@(posedge tck_i)
    state == ST_RESET |=>
      ir == INS_BYPASS)
    else $error("reset did not select bypass");

  chk_bypass_capture: assert property (@(posedge tck_i)
    state == ST_CAP_DR && ins_bypass_like |=>
      !byp)
    else $error("bypass capture not zero");

  chk_bypass_out: assert property (@(negedge tck_i)
    state == ST_SH_DR && ins_bypass_like |=>
      tdo_n == $past(byp))
    else $error("bypass bit not on data output");

  chk_dr_capture: assert property (@(posedge tck_i)
    state == ST_CAP_DR && !ins_bypass_like |=>
      bsr_cap == $past(cap_vec))
    else $error("boundary capture wrong");

  chk_dr_shift_in: assert property (@(posedge tck_i)
    s_dr_shift_step |=>
      bsr_cap == {$past(tdi_i), $past(bsr_cap[BSR_W-1:1])})
    else $error("boundary shift wrong");

  chk_dr_out_bit: assert property (@(negedge tck_i)
    s_dr_shift_step |=>
      tdo_n == $past(bsr_cap[0]))
    else $error("boundary bit not on data output");

  chk_upd_toggle: assert property (@(posedge tck_i)
    state == ST_UPD_DR && !ins_bypass_like |=>
      upd_tgl != $past(upd_tgl))
    else $error("update toggle did not flip");

  chk_tdo_en_idle: assert property (@(negedge tck_i)
    state != ST_SH_IR && state != ST_SH_DR |=>
      !tdo_en)
    else $error("data output enabled outside shift");

  chk_core_path: assert property (@(posedge sys_clk_i)
    disable iff (srst_i)
    !ext_s2 |=>
      pin_out_o == $past(core_out_i) && pin_oe_o == $past(core_oe_i))
    else $error("core drive not passed to pins");

  chk_extest_release: assert property (@(posedge sys_clk_i)
    disable iff (srst_i)
    ext_s2 && upd_hold[2] |=>
      !pin_oe_o[0])
    else $error("pin driven with enable cell high");

  chk_inbuf_on: assert property (@(posedge sys_clk_i)
    disable iff (srst_i)
    always_enable_inbuf_i |->
      ##2 core_in_o == $past(pin_s2, 2))
    else $error("input buffers not all on");
endmodule : bstap_top

// file: hdl/bstap_pkg.sv
// Constants for the boundary-scan test access port.
// Assumes a test clock domain at the link and a system clock at the core.
package bstap_pkg;
  localparam int IR_W = 10;
  localparam logic [IR_W-1:0] IR_CAPTURE = 10'h2aa;
  localparam logic [IR_W-1:0] INS_BYPASS = 10'h3ff;
  localparam logic [IR_W-1:0] INS_EXTEST = 10'h00f;
  localparam logic [IR_W-1:0] INS_SAMPLE = 10'h005;
  localparam logic [IR_W-1:0] INS_CLAMP = 10'h00a;
  localparam logic [IR_W-1:0] INS_HIGHZ = 10'h00b;
  localparam int RST_TMS_ONES = 5;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
    ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
    ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bstap_state_e;

  function automatic bstap_state_e bstap_next(bstap_state_e s, logic m);
    unique case (s)
      ST_RESET: bstap_next = m ? ST_RESET : ST_IDLE;
      ST_IDLE: bstap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: bstap_next = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: bstap_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: bstap_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: bstap_next = m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: bstap_next = m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: bstap_next = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: bstap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: bstap_next = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: bstap_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: bstap_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: bstap_next = m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: bstap_next = m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: bstap_next = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: bstap_next = m ? ST_SEL_DR : ST_IDLE;
    endcase
  endfunction : bstap_next
endpackage : bstap_pkg

// file: tb/bstap_tester.sv
// Test controller model that drives the scan port pins.
// Assumes the data output is read back through the system clock.
`timescale 1ns/10ps
module bstap_tester (
  input wire logic sys_clk_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  initial begin
    tck_o = 1'b0; // Idle levels
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // One clock pulse, then read the resynchronised output
  task automatic step(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #32 tck_o = 1'b1;
    #32 tck_o = 1'b0;
    tdi_o = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    q = tdo_i;
  endtask : step

  task automatic reset_tap();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
  endtask : reset_tap

  // Scan n bits from idle; first bit out is the captured one
  task automatic scan(input bit ir, input logic [11:0] din, input int n,
                      output logic [11:0] dout);
    logic q;
    dout = 12'h000;
    step(1'b0, 1'b1, q);
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    dout[0] = q;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      if (i < n - 1) dout[i+1] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    tms_o = 1'b1;
  endtask : scan
endmodule : bstap_tester

// file: tb/tb.sv
// Self-checking bench for the scan port and its pin cells.
// Assumes the tester model drives all test pins.
`timescale 1ns/10ps
module tb import bstap_pkg::*;;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic tck, tms, tdi, tdo, ext, toe;
  logic in_system_programming = 1'b0, prog = 1'b0, aen = 1'b0;
  logic [3:0] oonly = 4'h0, cout = 4'ha, coe = 4'h0, pin_in = 4'h9;
  logic [3:0] pout, poe, cin;
  logic [11:0] cap;
  int err_count = 0;
  int tests_run = 0;

  always #20 sys_clk = ~sys_clk;

  bstap_top #(.NPIN(4)) dut_u (.sys_clk_i(sys_clk), .srst_i(srst),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(toe),
    .in_system_programming_i(in_system_programming), .programmed_i(prog),
    .always_enable_inbuf_i(aen), .pin_output_only_i(oonly),
    .core_out_i(cout), .core_oe_i(coe), .pin_in_i(pin_in),
    .pin_out_o(pout), .pin_oe_o(poe), .core_in_o(cin),
    .extest_active_o(ext));

  bstap_tester tst_u (.sys_clk_i(sys_clk), .tdo_i(tdo), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi));

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("errors=%0d checks=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic t_powerup();
    tst_u.scan(1'b0, 12'h001, 2, cap);
    chk(cap, 12'h002);
    chk({11'h000, toe}, 12'h000);
  endtask : t_powerup

  task automatic t_irpat();
    tst_u.reset_tap();
    tst_u.scan(1'b1, {2'h0, INS_BYPASS}, 10, cap);
    chk(cap, {2'h0, IR_CAPTURE});
  endtask : t_irpat

  task automatic t_extest();
    tst_u.scan(1'b1, {2'h0, INS_SAMPLE}, 10, cap);
    tst_u.scan(1'b0, 12'h082, 12, cap);
    tst_u.scan(1'b1, {2'h0, INS_EXTEST}, 10, cap);
    repeat (8) @(posedge sys_clk);
    chk({ext, 3'h0, poe, pout}, 12'h8f5);
    tst_u.scan(1'b0, 12'h000, 12, cap);
    chk(cap & 12'h249, 12'h201);
    repeat (8) @(posedge sys_clk);
    chk({ext, 3'h0, poe, pout}, 12'h8f0);
  endtask : t_extest

  task automatic t_isp();
    @(posedge sys_clk);
    in_system_programming <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      tst_u.scan(1'b1, {2'h0, k ? INS_SAMPLE : INS_EXTEST}, 10, cap);
      tst_u.scan(1'b0, 12'h001, 2, cap);
      chk({ext, 1'b0, cap[1:0], 4'h0, pout}, 12'h20a);
    end
    @(posedge sys_clk);
    in_system_programming <= 1'b0;
  endtask : t_isp

  task automatic t_inbuf();
    @(posedge sys_clk);
    prog <= 1'b1;
    oonly <= 4'h3;
    pin_in <= 4'hf;
    repeat (6) @(posedge sys_clk);
    chk({8'h00, cin}, 12'h00c);
    aen <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({8'h00, cin}, 12'h00f);
  endtask : t_inbuf

  initial begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_powerup();
    t_irpat();
    t_extest();
    t_isp();
    t_inbuf();
    conclude();
  end

  initial begin
    #2000000;
    err_count++;
    conclude();
  end
endmodule : tb
